// ==== tfpf_top.sv ====
// register file, fault logic and input filters
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module tfpf_top #(
  parameter int NUM_CH  = 8,
  parameter int NUM_CAP = 6
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // channel side
  input  wire logic [NUM_CH-1:0]  pwm_raw,
  output logic      [NUM_CH-1:0]  ch_out,
  input  wire logic [NUM_CAP-1:0] cap_in,
  output logic      [NUM_CAP-1:0] cap_filtered,
  input  wire logic               fault_in
);
  localparam int CNT_W_L = tfpf_pkg::CNT_W;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           polarity;
    logic [7:0]           filt01;
    logic [7:0]           filt23;
    logic [3:0]           ffilt;
    logic                 flt_en;
    logic                 wp_dis;
    logic                 fault_flag;
    logic                 clr_armed;
    logic                 wp_armed;
    logic                 fault_lvl;
    logic [1:0]           fault_sync;
    logic [1:0]           fault_sync2;
    logic [CNT_W_L-1:0]   fcnt;
    logic                 ffilt_out;
    logic [NUM_CAP-1:0]   cap_s1;
    logic [NUM_CAP-1:0]   cap_s2;
    logic [4*CNT_W_L-1:0] ccnt;
    logic [NUM_CAP-1:0]   cap_out;
    logic [NUM_CH-1:0]    pwm_s1;
    logic [NUM_CH-1:0]    pwm_s2;
    logic [NUM_CH-1:0]    chout;
    logic [31:0]          rdata;
    logic                 ready;
  } tfpf_state_type;

  tfpf_state_type st;
  tfpf_state_type next_st;

  logic [7:0] fms_view;
  logic       wr_acc;
  logic       rd_acc;
  logic       fault_event;

  // filter threshold from a 4-bit value
  function automatic logic [CNT_W_L-1:0] thr(input logic [3:0] v);
    thr = CNT_W_L'(v) << tfpf_pkg::FILT_SHIFT;
  endfunction

  always_comb begin
    fms_view = {st.fault_flag, ~st.wp_dis, st.fault_lvl, 5'h00};
  end

  assign wr_acc = psel & penable & pwrite & ~st.ready;
  assign rd_acc = psel & penable & ~pwrite & ~st.ready;
  assign fault_event = st.flt_en & st.ffilt_out;

  always_comb begin
    logic [3:0] fv;
    logic       cin;
    fv  = 4'h0;
    cin = 1'b0;
    next_st = st;
    next_st.ready = 1'b0;
    // ------------------------------------------------------------
    // synchronisers, single domain
    // ------------------------------------------------------------
    next_st.fault_sync  = {st.fault_sync[0], fault_in};
    next_st.fault_sync2 = {st.fault_sync2[0], st.fault_sync[1]};
    next_st.cap_s1 = cap_in;
    next_st.cap_s2 = st.cap_s1;
    next_st.pwm_s1 = pwm_raw;
    next_st.pwm_s2 = st.pwm_s1;
    // ------------------------------------------------------------
    // fault filter
    // ------------------------------------------------------------
    if (st.ffilt == 4'h0) begin
      next_st.ffilt_out = st.fault_sync2[0];
      next_st.fcnt = '0;
    end else if (st.fault_sync2[0] == st.ffilt_out) begin
      next_st.fcnt = '0;
    end else if (st.fcnt >= thr(st.ffilt)) begin
      next_st.ffilt_out = st.fault_sync2[0];
      next_st.fcnt = '0;
    end else begin
      next_st.fcnt = st.fcnt + 1'b1;
    end
    if (st.flt_en) begin
      next_st.fault_lvl = st.ffilt_out;
    end
    // ------------------------------------------------------------
    // capture filters, channels 0-3 only
    // ------------------------------------------------------------
    for (int i = 0; i < NUM_CAP; i++) begin
      cin = st.cap_s2[i];
      if (i >= 4) begin
        next_st.cap_out[i] = cin;
      end else begin
        fv = (i < 2) ? st.filt01[4*(i%2) +: 4] : st.filt23[4*(i%2) +: 4];
        if (fv == 4'h0) begin
          next_st.cap_out[i] = cin;
          next_st.ccnt[CNT_W_L*i +: CNT_W_L] = '0;
        end else if (cin == st.cap_out[i]) begin
          next_st.ccnt[CNT_W_L*i +: CNT_W_L] = '0;
        end else if (st.ccnt[CNT_W_L*i +: CNT_W_L] >= thr(fv)) begin
          next_st.cap_out[i] = cin;
          next_st.ccnt[CNT_W_L*i +: CNT_W_L] = '0;
        end else begin
          next_st.ccnt[CNT_W_L*i +: CNT_W_L] =
            st.ccnt[CNT_W_L*i +: CNT_W_L] + 1'b1;
        end
      end
    end
    // ------------------------------------------------------------
    // channel outputs
    // ------------------------------------------------------------
    if (st.flt_en && st.fault_flag) begin
      next_st.chout = st.polarity;
    end else begin
      next_st.chout = st.pwm_s2 ^ st.polarity;
    end
    // ------------------------------------------------------------
    // apb reads
    // ------------------------------------------------------------
    if (rd_acc) begin
      next_st.ready = 1'b1;
      case (paddr)
        tfpf_pkg::ADDR_POLARITY:  next_st.rdata = {24'h0, st.polarity};
        tfpf_pkg::ADDR_FAULT_ST: begin
          next_st.rdata = {24'h0, fms_view};
          if (st.fault_flag) begin
            next_st.clr_armed = 1'b1;
          end
          if (!st.wp_dis) begin
            next_st.wp_armed = 1'b1;
          end
        end
        tfpf_pkg::ADDR_FILT_CH01: next_st.rdata = {24'h0, st.filt01};
        tfpf_pkg::ADDR_FILT_CH23: next_st.rdata = {24'h0, st.filt23};
        tfpf_pkg::ADDR_FLT_FILT:  next_st.rdata = {28'h0, st.ffilt};
        tfpf_pkg::ADDR_RESERVED:
          next_st.rdata = {24'h0, tfpf_pkg::RESERVED_VAL};
        tfpf_pkg::ADDR_CONTROL:
          next_st.rdata = {30'h0, st.wp_dis, st.flt_en};
        default:                  next_st.rdata = 32'h0;
      endcase
    end
    // ------------------------------------------------------------
    // apb writes
    // ------------------------------------------------------------
    if (wr_acc) begin
      next_st.ready = 1'b1;
      case (paddr)
        tfpf_pkg::ADDR_POLARITY: begin
          if (st.wp_dis) begin
            next_st.polarity = pwdata[7:0];
          end
        end
        tfpf_pkg::ADDR_FAULT_ST: begin
          if (!pwdata[tfpf_pkg::FAULT_FLAG_BIT] && st.clr_armed) begin
            next_st.fault_flag = 1'b0;
            next_st.clr_armed  = 1'b0;
          end
          if (pwdata[tfpf_pkg::PROT_EN_BIT]) begin
            next_st.wp_dis = 1'b0;
          end
        end
        tfpf_pkg::ADDR_FILT_CH01: next_st.filt01 = pwdata[7:0];
        tfpf_pkg::ADDR_FILT_CH23: next_st.filt23 = pwdata[7:0];
        tfpf_pkg::ADDR_FLT_FILT:  next_st.ffilt = pwdata[3:0];
        tfpf_pkg::ADDR_CONTROL: begin
          next_st.flt_en = pwdata[tfpf_pkg::CTRL_FLT_EN];
          if (pwdata[tfpf_pkg::CTRL_WP_DIS] && st.wp_armed) begin
            next_st.wp_dis   = 1'b1;
            next_st.wp_armed = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // fault set wins over clear and restarts the sequence
    if (fault_event) begin
      next_st.fault_flag = 1'b1;
      next_st.clr_armed  = 1'b0;
    end
    if (!st.flt_en) begin
      next_st.fault_lvl = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.polarity <= tfpf_pkg::POLARITY_RST;
      st.filt01   <= tfpf_pkg::FILTER_RST;
      st.filt23   <= tfpf_pkg::FILTER_RST;
      st.ffilt    <= tfpf_pkg::FFILT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata       = st.rdata;
  assign pready       = st.ready;
  assign pslverr      = 1'b0;
  assign ch_out       = st.chout;
  assign cap_filtered = st.cap_out;
endmodule

// ==== tfpf_pkg.sv ====
// constants for the timer fault, polarity and filter block
package tfpf_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_POLARITY  = 8'h00;
  localparam logic [7:0] ADDR_FAULT_ST  = 8'h04;
  localparam logic [7:0] ADDR_FILT_CH01 = 8'h08;
  localparam logic [7:0] ADDR_FILT_CH23 = 8'h0C;
  localparam logic [7:0] ADDR_FLT_FILT  = 8'h10;
  localparam logic [7:0] ADDR_RESERVED  = 8'h14;
  localparam logic [7:0] ADDR_CONTROL   = 8'h18;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int FAULT_FLAG_BIT = 7;
  localparam int PROT_EN_BIT    = 6;
  localparam int FAULT_LVL_BIT  = 5;
  localparam int CTRL_FLT_EN    = 0;
  localparam int CTRL_WP_DIS    = 1;
  // ------------------------------------------------------------
  // reset values and filter scaling
  // ------------------------------------------------------------
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic [7:0] FILTER_RST   = 8'h00;
  localparam logic [3:0] FFILT_RST    = 4'h0;
  localparam logic [7:0] RESERVED_VAL = 8'h00;
  localparam int         FILT_SHIFT   = 2;
  localparam int         CNT_W        = 6;
endpackage

// ==== tfpf_assertions.sv ====
// checker for the apb and capture ports of the fault and filter block
`timescale 1ns/1ps
module tfpf_checker #(
  parameter int NUM_CAP = 6
) (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb slave
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  // capture side
  input wire logic [NUM_CAP-1:0] cap_in,
  input wire logic [NUM_CAP-1:0] cap_filtered
);
  logic rd_st;
  logic flag_rd;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign rd_st = pready && !pwrite && paddr == tfpf_pkg::ADDR_FAULT_ST;
  // flag value software saw at its last status read, zeroed by a status write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_rd <= 1'h0;
    end else if (pready && paddr == tfpf_pkg::ADDR_FAULT_ST) begin
      flag_rd <= rd_st && prdata[7];
    end
  end
  rsvd_zero_a: assert property (pready && !pwrite &&
    paddr == tfpf_pkg::ADDR_RESERVED |-> prdata == 32'h0) else $error("rsvd");
  fflt_upper_a: assert property (pready && !pwrite &&
    paddr == tfpf_pkg::ADDR_FLT_FILT |-> prdata[31:4] == 28'h0) else $error("ff");
  flag_hold_a: assert property (rd_st && flag_rd |-> prdata[7])
    else $error("flag lost without write");
  unfilt_ch4_a: assert property (cap_filtered[4] == $past(cap_in[4], 3))
    else $error("ch4 filtered");
  unfilt_ch5_a: assert property (cap_filtered[5] == $past(cap_in[5], 3))
    else $error("ch5 filtered");
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready long");
  rst_clear_a: assert property ($rose(presetn) |-> cap_filtered == '0)
    else $error("not cleared");
  fault_seen_c: cover property (rd_st && prdata[7]);
  prot_off_c: cover property (rd_st && !prdata[6]);
  filt_pass_c: cover property ($rose(cap_filtered[1]));
endmodule
bind tfpf_top tfpf_checker #(.NUM_CAP(NUM_CAP)) u_tfpf_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .cap_in(cap_in), .cap_filtered(cap_filtered));

// ==== tfpf_tb.sv ====
// self-checking testbench for the fault, polarity and filter block
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] POL = tfpf_pkg::ADDR_POLARITY;
  localparam logic [7:0] ST  = tfpf_pkg::ADDR_FAULT_ST;
  localparam logic [7:0] CTL = tfpf_pkg::ADDR_CONTROL;
  localparam logic [7:0] FF  = tfpf_pkg::ADDR_FLT_FILT;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pwm_raw = 8'h00;
  logic [7:0]  ch_out;
  logic [5:0]  cap_in = 6'h00;
  logic [5:0]  cap_filtered;
  logic        fault_in = 1'h0;
  int          num_errors = 0;
  int          samples_checked = 0;
  `define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    num_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
  always #5 pclk = ~pclk;
  tfpf_top u_tfpf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_raw(pwm_raw),
    .ch_out(ch_out), .cap_in(cap_in), .cap_filtered(cap_filtered),
    .fault_in(fault_in));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    repeat (20) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    `CHK("pready", 1'h1, pready)
    `CHK("pslverr", 1'h0, pslverr)
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string nm);
    logic [31:0] q;
    apb(1'h0, a, 32'h0, q);
    `CHK(nm, e, q & m)
  endtask
  task automatic pulse(input int n);
    fault_in <= 1'h1;
    repeat (n) @(posedge pclk);
    fault_in <= 1'h0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic t_protect;
    rd(ST, 32'hFFFFFFFF, 32'h40, "st rst");
    rd(tfpf_pkg::ADDR_RESERVED, 32'hFFFFFFFF, 32'h0, "rsvd");
    wr(POL, 32'hA5);
    rd(POL, 32'hFF, 32'h00, "pol locked");
    wr(ST, 32'h00);
    rd(ST, 32'h40, 32'h40, "write_protect_enable keep");
    wr(CTL, 32'h02);
    rd(ST, 32'h40, 32'h00, "write_protect_enable clr");
    wr(POL, 32'hA5);
    rd(POL, 32'hFF, 32'hA5, "pol open");
    repeat (5) @(posedge pclk);
    `CHK("ch idle", 8'hA5, ch_out)
    pwm_raw <= 8'hFF;
    repeat (5) @(posedge pclk);
    `CHK("ch act", 8'h5A, ch_out)
    wr(ST, 32'h40);
    rd(ST, 32'h40, 32'h40, "write_protect_enable set");
    wr(POL, 32'h00);
    rd(POL, 32'hFF, 32'hA5, "pol relock");
    $display("test protect done");
  endtask
  task automatic t_fault;
    wr(FF, 32'h0F);
    rd(FF, 32'hFFFFFFFF, 32'h0F, "fault_filter_value");
    wr(CTL, 32'h01);
    pulse(5);
    rd(ST, 32'h80, 32'h00, "glitch");
    wr(CTL, 32'h00);
    wr(FF, 32'h00);
    wr(CTL, 32'h01);
    fault_in <= 1'h1;
    repeat (12) @(posedge pclk);
    `CHK("safe", 8'hA5, ch_out)
    rd(ST, 32'hA0, 32'hA0, "fault");
    fault_in <= 1'h0;
    repeat (12) @(posedge pclk);
    rd(ST, 32'hA0, 32'h80, "fault low");
    wr(ST, 32'h00);
    rd(ST, 32'h80, 32'h00, "cleared");
    pulse(3);
    wr(ST, 32'h00);
    rd(ST, 32'h80, 32'h80, "no read");
    pulse(3);
    wr(ST, 32'h00);
    rd(ST, 32'h80, 32'h80, "refault");
    wr(ST, 32'h80);
    rd(ST, 32'h80, 32'h80, "wr one");
    wr(ST, 32'h00);
    rd(ST, 32'h80, 32'h00, "clr again");
    $display("test fault done");
  endtask
  task automatic t_filter;
    wr(tfpf_pkg::ADDR_FILT_CH01, 32'h30);
    rd(tfpf_pkg::ADDR_FILT_CH01, 32'hFF, 32'h30, "f01");
    cap_in <= 6'h13;
    repeat (5) @(posedge pclk);
    `CHK("bypass", 6'h11, cap_filtered)
    repeat (20) @(posedge pclk);
    `CHK("filtered", 6'h13, cap_filtered)
    cap_in <= 6'h00;
    $display("test filter done");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_protect();
    t_fault();
    t_filter();
    stop_test();
  end
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule
